// ===== shared/serial_bus_pkg.sv
// Constants and carrier types for the serial-bus byte access engine.
// Assumes a byte-wide configuration port and a separate link clock.
package serial_bus_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] DATA_OFFSET = 8'hB0;
    localparam logic [7:0] INDEX_OFFSET = 8'hB1;
    localparam logic [7:0] TARGET_OFFSET = 8'hB2;
    localparam logic [7:0] CTRL_OFFSET = 8'hB3;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam int CTRL_SHORT_BIT = 7;
    localparam int CTRL_BUSY_BIT = 5;
    localparam int CTRL_FAST_BIT = 2;
    localparam int CTRL_ERR_BIT = 1;
    localparam int DIR_BIT = 0;

    // ------------------------------------------------------------
    // Serial clock timing
    // ------------------------------------------------------------
    localparam int SCL_PERIOD_NS = 10000;
    localparam int LINK_PERIOD_NS = 12;
    localparam int QUARTERS_PER_BIT = 4;
    localparam int FAST_RATIO = 8;
    localparam int DIV_W = 12;
    localparam int QUARTER_NORMAL =
        SCL_PERIOD_NS / (QUARTERS_PER_BIT * LINK_PERIOD_NS);
    localparam int QUARTER_FAST = QUARTER_NORMAL / FAST_RATIO;
    localparam logic [3:0] LAST_BIT = 4'h8;
    localparam logic [1:0] SAMPLE_PHASE = 2'h2;
    localparam logic [1:0] LAST_PHASE = 2'h3;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef enum logic [1:0] {OP_START, OP_STOP, OP_WRITE, OP_READ} bit_op_t;

    typedef struct packed {
        bit_op_t op;
        logic [7:0] data;
        logic nack;
    } bit_cmd_t;

    typedef struct packed {
        logic short_form_select;
        logic fast_clock_test;
        logic [6:0] target_addr;
        logic direction_bit;
        logic [7:0] byte_offset;
        logic [7:0] transfer_byte;
    } request_t;

    typedef struct packed {
        logic [7:0] transfer_byte;
        logic error;
    } result_t;

endpackage

// ===== src/serial_bit_engine.sv
// Bit-level two-wire engine: start, stop, and nine-bit byte slots.
// Runs on the link clock; lines are open drain, synchronised here.
module serial_bit_engine (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Command
    input wire logic go,
    input wire serial_bus_pkg::bit_cmd_t cmd,
    input wire logic [serial_bus_pkg::DIV_W-1:0] quarter,
    output logic done,
    output logic [7:0] rx_byte,
    output logic ack_seen,
    // Lines
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_n,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n
);
    // ------------------------------------------------------------
    // Line levels per quarter phase, {scl, sda}
    // ------------------------------------------------------------
    function automatic logic [1:0] line_levels(
        serial_bus_pkg::bit_op_t op, logic [1:0] ph, logic b);
        logic [1:0] lv;
        lv = 2'h3;
        unique case (op)
            serial_bus_pkg::OP_START:
                lv = (ph == 2'h0) ? 2'h1 : (ph == 2'h1) ? 2'h3 :
                     (ph == 2'h2) ? 2'h2 : 2'h0;
            serial_bus_pkg::OP_STOP:
                lv = (ph == 2'h0) ? 2'h0 : (ph == 2'h1) ? 2'h2 : 2'h3;
            serial_bus_pkg::OP_WRITE, serial_bus_pkg::OP_READ:
                lv = {(ph == 2'h1) || (ph == 2'h2), b};
        endcase
        return lv;
    endfunction

    logic scl_s1_q, scl_s2_q, sda_s1_q, sda_s2_q;
    logic busy_q, busy_d, done_q, done_d;
    logic scl_low_q, scl_low_d, sda_low_q, sda_low_d;
    logic [1:0] phase_q, phase_d, lv;
    logic [3:0] bit_q, bit_d;
    logic [serial_bus_pkg::DIV_W-1:0] cnt_q, cnt_d;
    logic [8:0] shift_q, shift_d, rx_q, rx_d;
    serial_bus_pkg::bit_cmd_t cmd_q, cmd_d;
    logic is_byte, stretch;

    // ------------------------------------------------------------
    // Sequencing
    // ------------------------------------------------------------
    always_comb
    begin
        busy_d = busy_q;
        done_d = 1'b0;
        phase_d = phase_q;
        bit_d = bit_q;
        cnt_d = cnt_q;
        shift_d = shift_q;
        rx_d = rx_q;
        cmd_d = cmd_q;
        scl_low_d = scl_low_q;
        sda_low_d = sda_low_q;
        lv = 2'h3;
        is_byte = (cmd_q.op == serial_bus_pkg::OP_WRITE) ||
                  (cmd_q.op == serial_bus_pkg::OP_READ);
        // Target may hold the clock low; wait until it lets go
        stretch = busy_q && !scl_low_q && !scl_s2_q;
        if (!busy_q)
        begin
            if (go)
            begin
                busy_d = 1'b1;
                cmd_d = cmd;
                phase_d = 2'h0;
                bit_d = 4'h0;
                cnt_d = quarter - 1'b1;
                // Ack slot released on writes, nack driven on reads
                shift_d = (cmd.op == serial_bus_pkg::OP_READ) ?
                          {8'hFF, cmd.nack} : {cmd.data, 1'b1};
            end
        end
        else if (stretch)
        begin
            cnt_d = cnt_q;
        end
        else if (cnt_q != '0)
        begin
            cnt_d = cnt_q - 1'b1;
        end
        else
        begin
            cnt_d = quarter - 1'b1;
            if (phase_q == serial_bus_pkg::SAMPLE_PHASE && is_byte)
                rx_d = {rx_q[7:0], sda_s2_q};
            if (phase_q != serial_bus_pkg::LAST_PHASE)
                phase_d = phase_q + 1'b1;
            else
            begin
                phase_d = 2'h0;
                if (is_byte && bit_q != serial_bus_pkg::LAST_BIT)
                begin
                    bit_d = bit_q + 1'b1;
                    shift_d = {shift_q[7:0], 1'b1};
                end
                else
                begin
                    busy_d = 1'b0;
                    done_d = 1'b1;
                end
            end
        end
        // Idle keeps the last levels: low clock after a byte
        if (busy_d)
        begin
            lv = line_levels(cmd_d.op, phase_d, shift_d[8]);
            scl_low_d = !lv[1];
            sda_low_d = !lv[0];
        end
    end

    always_ff @(posedge clk)
    begin
        scl_s1_q <= scl_i;
        scl_s2_q <= scl_s1_q;
        sda_s1_q <= sda_i;
        sda_s2_q <= sda_s1_q;
        if (rst)
        begin
            busy_q <= 1'b0;
            done_q <= 1'b0;
            phase_q <= 2'h0;
            bit_q <= 4'h0;
            cnt_q <= '0;
            shift_q <= '0;
            rx_q <= '0;
            cmd_q <= '0;
            scl_low_q <= 1'b0;
            sda_low_q <= 1'b0;
        end
        else
        begin
            busy_q <= busy_d;
            done_q <= done_d;
            phase_q <= phase_d;
            bit_q <= bit_d;
            cnt_q <= cnt_d;
            shift_q <= shift_d;
            rx_q <= rx_d;
            cmd_q <= cmd_d;
            scl_low_q <= scl_low_d;
            sda_low_q <= sda_low_d;
        end
    end

    assign done = done_q;
    assign rx_byte = rx_q[8:1];
    assign ack_seen = !rx_q[0];
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;
    assign scl_oe_n = !scl_low_q;
    assign sda_oe_n = !sda_low_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    data_stable_a: assert property (
        @(posedge clk) disable iff (rst)
        busy_q && is_byte && !scl_low_q && $past(!scl_low_q)
        |-> sda_low_q == $past(sda_low_q))
        else $error("data changed while clock high");

    quarter_len_a: assert property (
        @(posedge clk) disable iff (rst)
        busy_q && $changed(phase_q)
        |-> cnt_q == quarter - 1'b1)
        else $error("quarter period not reloaded");

endmodule

// ===== src/host_serial_bus_byte_access.sv
// Register-driven byte read/write engine for a two-wire serial bus.
// Assumes a byte-wide configuration port on clk and a free link clock.
module host_serial_bus_byte_access #(
    parameter int QUARTER_NORMAL_CYC = serial_bus_pkg::QUARTER_NORMAL,
    parameter int QUARTER_FAST_CYC = serial_bus_pkg::QUARTER_FAST
) (
    // Core clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Link clock
    input wire logic link_clk,
    // Configuration port
    input wire logic [7:0] cfg_addr,
    input wire logic cfg_wr,
    input wire logic [7:0] cfg_wdata,
    input wire logic cfg_rd,
    output logic [7:0] cfg_rdata,
    // Serial lines
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_n,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n
);
    typedef enum {S_IDLE, S_START, S_ADDR_W, S_INDEX, S_DATA, S_RESTART,
                  S_ADDR_R, S_READ, S_STOP} seq_state_t;

    // ------------------------------------------------------------
    // Core-domain registers
    // ------------------------------------------------------------
    logic [7:0] data_q, data_d, index_q, index_d, target_q, target_d;
    logic [7:0] rdata_q, rdata_d;
    logic short_q, short_d, fast_q, fast_d, busy_q, busy_d, err_q, err_d;
    logic req_tgl_q, req_tgl_d;
    logic done_tgl_q, done_tgl_d;
    logic done_s1_q, done_s2_q, done_s3_q, done_edge, wr_ok;
    serial_bus_pkg::request_t req_w;
    serial_bus_pkg::result_t result_q, result_d;

    function automatic logic [7:0] read_mux(logic [7:0] a, logic [7:0] d,
        logic [7:0] i, logic [7:0] t, logic s, logic b, logic f, logic e);
        logic [7:0] r;
        r = 8'h00;
        if (a == serial_bus_pkg::DATA_OFFSET)
            r = d;
        else if (a == serial_bus_pkg::INDEX_OFFSET)
            r = i;
        else if (a == serial_bus_pkg::TARGET_OFFSET)
            r = t;
        else if (a == serial_bus_pkg::CTRL_OFFSET)
        begin
            r[serial_bus_pkg::CTRL_SHORT_BIT] = s;
            r[serial_bus_pkg::CTRL_BUSY_BIT] = b;
            r[serial_bus_pkg::CTRL_FAST_BIT] = f;
            r[serial_bus_pkg::CTRL_ERR_BIT] = e;
        end
        return r;
    endfunction

    assign done_edge = done_s2_q ^ done_s3_q;
    // Request fields frozen while busy, so the link may sample them
    assign wr_ok = cfg_wr && !busy_q;
    assign req_w = '{short_q, fast_q, target_q[7:1],
                     target_q[serial_bus_pkg::DIR_BIT], index_q, data_q};

    always_comb
    begin
        data_d = data_q;
        index_d = index_q;
        target_d = target_q;
        short_d = short_q;
        fast_d = fast_q;
        busy_d = busy_q;
        err_d = err_q;
        req_tgl_d = req_tgl_q;
        rdata_d = rdata_q;
        if (wr_ok && cfg_addr == serial_bus_pkg::DATA_OFFSET)
            data_d = cfg_wdata;
        if (wr_ok && cfg_addr == serial_bus_pkg::INDEX_OFFSET)
            index_d = cfg_wdata;
        if (wr_ok && cfg_addr == serial_bus_pkg::TARGET_OFFSET)
        begin
            target_d = cfg_wdata;
            busy_d = 1'b1;
            req_tgl_d = !req_tgl_q;
        end
        if (wr_ok && cfg_addr == serial_bus_pkg::CTRL_OFFSET)
        begin
            short_d = cfg_wdata[serial_bus_pkg::CTRL_SHORT_BIT];
            fast_d = cfg_wdata[serial_bus_pkg::CTRL_FAST_BIT];
        end
        if (cfg_wr && cfg_addr == serial_bus_pkg::CTRL_OFFSET &&
            cfg_wdata[serial_bus_pkg::CTRL_ERR_BIT])
            err_d = 1'b0;
        if (done_edge)
        begin
            busy_d = 1'b0;
            if (target_q[serial_bus_pkg::DIR_BIT])
                data_d = result_q.transfer_byte;
            // Set after clear: a new error is never lost
            if (result_q.error)
                err_d = 1'b1;
        end
        if (cfg_rd)
            rdata_d = read_mux(cfg_addr, data_q, index_q, target_q,
                               short_q, busy_q, fast_q, err_q);
    end

    always_ff @(posedge clk)
    begin
        done_s1_q <= done_tgl_q;
        done_s2_q <= done_s1_q;
        done_s3_q <= done_s2_q;
        if (sys_rst)
        begin
            data_q <= serial_bus_pkg::REG_RESET;
            index_q <= serial_bus_pkg::REG_RESET;
            target_q <= serial_bus_pkg::REG_RESET;
            rdata_q <= serial_bus_pkg::REG_RESET;
            short_q <= 1'b0;
            fast_q <= 1'b0;
            busy_q <= 1'b0;
            err_q <= 1'b0;
            req_tgl_q <= 1'b0;
        end
        else
        begin
            data_q <= data_d;
            index_q <= index_d;
            target_q <= target_d;
            rdata_q <= rdata_d;
            short_q <= short_d;
            fast_q <= fast_d;
            busy_q <= busy_d;
            err_q <= err_d;
            req_tgl_q <= req_tgl_d;
        end
    end

    assign cfg_rdata = rdata_q;

    // ------------------------------------------------------------
    // Link-domain sequencer
    // ------------------------------------------------------------
    logic rst_s1_q, link_rst, req_s1_q, req_s2_q, req_s3_q, req_edge;
    logic go_q, go_d;
    logic eng_done, eng_ack;
    logic [7:0] eng_rx;
    logic [serial_bus_pkg::DIV_W-1:0] quarter;
    seq_state_t st_q, st_d;
    serial_bus_pkg::request_t lreq_q, lreq_d;
    serial_bus_pkg::bit_cmd_t cmd_q, cmd_d;

    function automatic serial_bus_pkg::bit_cmd_t cmd_for(seq_state_t s,
        serial_bus_pkg::request_t r);
        serial_bus_pkg::bit_cmd_t c;
        c = '{serial_bus_pkg::OP_WRITE, 8'h00, 1'b0};
        unique case (s)
            S_START, S_RESTART: c.op = serial_bus_pkg::OP_START;
            S_STOP: c.op = serial_bus_pkg::OP_STOP;
            S_ADDR_W: c.data = {r.target_addr, 1'b0};
            S_ADDR_R: c.data = {r.target_addr, r.direction_bit};
            S_INDEX: c.data = r.byte_offset;
            S_DATA: c.data = r.transfer_byte;
            S_READ: c = '{serial_bus_pkg::OP_READ, 8'h00, 1'b1};
            S_IDLE: c.op = serial_bus_pkg::OP_STOP;
        endcase
        return c;
    endfunction

    assign req_edge = req_s2_q ^ req_s3_q;
    assign quarter = lreq_q.fast_clock_test ?
        QUARTER_FAST_CYC[serial_bus_pkg::DIV_W-1:0] :
        QUARTER_NORMAL_CYC[serial_bus_pkg::DIV_W-1:0];

    always_comb
    begin
        st_d = st_q;
        lreq_d = lreq_q;
        result_d = result_q;
        done_tgl_d = done_tgl_q;
        unique case (st_q)
            S_IDLE:
                if (req_edge)
                begin
                    lreq_d = req_w;
                    result_d.error = 1'b0;
                    st_d = S_START;
                end
            S_START:
                if (eng_done)
                    st_d = (lreq_q.short_form_select && lreq_q.direction_bit)
                           ? S_ADDR_R : S_ADDR_W;
            S_ADDR_W:
                if (eng_done)
                    st_d = !eng_ack ? S_STOP :
                           lreq_q.short_form_select ? S_DATA : S_INDEX;
            S_INDEX:
                if (eng_done)
                    st_d = !eng_ack ? S_STOP :
                           lreq_q.direction_bit ? S_RESTART : S_DATA;
            S_DATA:
                if (eng_done)
                    st_d = S_STOP;
            S_RESTART:
                if (eng_done)
                    st_d = S_ADDR_R;
            S_ADDR_R:
                if (eng_done)
                    st_d = eng_ack ? S_READ : S_STOP;
            S_READ:
                if (eng_done)
                begin
                    result_d.transfer_byte = eng_rx;
                    st_d = S_STOP;
                end
            S_STOP:
                if (eng_done)
                begin
                    done_tgl_d = !done_tgl_q;
                    st_d = S_IDLE;
                end
        endcase
        if (eng_done && !eng_ack && (st_q == S_ADDR_W || st_q == S_INDEX ||
            st_q == S_DATA || st_q == S_ADDR_R))
            result_d.error = 1'b1;
        go_d = (st_d != st_q) && (st_d != S_IDLE);
        cmd_d = cmd_for(st_d, lreq_d);
    end

    always_ff @(posedge link_clk)
    begin
        rst_s1_q <= sys_rst;
        link_rst <= rst_s1_q;
        req_s1_q <= req_tgl_q;
        req_s2_q <= req_s1_q;
        if (link_rst)
        begin
            req_s3_q <= 1'b0;
            st_q <= S_IDLE;
            lreq_q <= '0;
            result_q <= '0;
            done_tgl_q <= 1'b0;
            go_q <= 1'b0;
            cmd_q <= '0;
        end
        else
        begin
            req_s3_q <= req_s2_q;
            st_q <= st_d;
            lreq_q <= lreq_d;
            result_q <= result_d;
            done_tgl_q <= done_tgl_d;
            go_q <= go_d;
            cmd_q <= cmd_d;
        end
    end

    serial_bit_engine u_engine (
        .clk(link_clk),
        .rst(link_rst),
        .go(go_q),
        .cmd(cmd_q),
        .quarter(quarter),
        .done(eng_done),
        .rx_byte(eng_rx),
        .ack_seen(eng_ack),
        .scl_i(scl_i),
        .scl_o(scl_o),
        .scl_oe_n(scl_oe_n),
        .sda_i(sda_i),
        .sda_o(sda_o),
        .sda_oe_n(sda_oe_n)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    busy_set_a: assert property (@(posedge clk) disable iff (sys_rst)
        cfg_wr && !busy_q && cfg_addr == serial_bus_pkg::TARGET_OFFSET
        |=> busy_q && req_tgl_q != $past(req_tgl_q))
        else $error("target write did not start access");

    busy_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
        busy_q && !done_edge |=> busy_q)
        else $error("busy dropped before completion");

    err_set_a: assert property (@(posedge clk) disable iff (sys_rst)
        done_edge && result_q.error |=> err_q)
        else $error("error flag not set");

    read_data_a: assert property (@(posedge clk) disable iff (sys_rst)
        done_edge && target_q[serial_bus_pkg::DIR_BIT]
        |=> data_q == $past(result_q.transfer_byte) && !busy_q)
        else $error("read byte not stored");

    reg_reset_a: assert property (@(posedge clk)
        sys_rst |=> data_q == serial_bus_pkg::REG_RESET &&
        index_q == serial_bus_pkg::REG_RESET &&
        target_q == serial_bus_pkg::REG_RESET && !busy_q)
        else $error("registers not cleared by reset");

    short_skip_a: assert property (@(posedge link_clk)
        disable iff (link_rst)
        st_q == S_INDEX |-> !lreq_q.short_form_select)
        else $error("index sent in short form");

    addr_read_a: assert property (@(posedge link_clk)
        disable iff (link_rst)
        go_q && st_q == S_ADDR_R
        |-> cmd_q.data == {lreq_q.target_addr, lreq_q.direction_bit})
        else $error("wrong address byte");

    index_byte_a: assert property (@(posedge link_clk)
        disable iff (link_rst)
        go_q && st_q == S_INDEX |-> cmd_q.data == lreq_q.byte_offset)
        else $error("wrong index byte");

endmodule

// ===== sim/serial_target_model.sv
// Behavioural two-wire target: one index register and a byte memory.
// Assumes pulled-up lines; a released line floats high.
module serial_target_model #(
    parameter logic [6:0] ADDR = 7'h50
) (
    // Wire levels
    input wire logic scl,
    input wire logic sda,
    // High pulls the data line low
    output logic sda_low,
    // Traffic seen
    output logic [7:0] last_index,
    output logic [7:0] last_data,
    output logic last_rw
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [256];
    logic [7:0] sh;
    logic [7:0] ptr;
    int n;
    int st;
    initial
    begin
        sda_low = 1'b0;
        n = 0;
        st = 4;
    end
    // ------------------------------------------------------------
    // Framing: start and stop
    // ------------------------------------------------------------
    always @(negedge sda)
        if (scl)
        begin
            n = 0;
            st = 0;
        end
    always @(posedge sda)
        if (scl)
            st = 4;
    // ------------------------------------------------------------
    // Bit slots; st 0 address, 1 index, 2 data, 3 reading, 4 idle, 5 done
    // ------------------------------------------------------------
    always @(posedge scl)
    begin
        if (n < 8)
            sh = {sh[6:0], sda};
        n = n + 1;
    end
    always @(negedge scl)
    begin
        if (n == 8 && st < 3)
        begin
            // Unknown address left unanswered, so the host sees a nack
            sda_low = (st > 0) || (sh[7:1] == ADDR);
            if (st == 0)
                last_rw = sh[0];
            if (st == 1)
                ptr = sh;
            if (st == 1)
                last_index = sh;
            if (st == 2)
                last_data = sh;
            if (st == 2)
                mem[ptr] = sh;
            st = !sda_low ? 4 : (st == 0) ? (sh[0] ? 3 : 1) : 2;
        end
        else if (n == 9)
        begin
            n = 0;
            sda_low = (st == 3) && !mem[ptr][7];
        end
        else if (st == 3 && n > 0)
        begin
            sda_low = (n < 8) && !mem[ptr][7 - n];
            // One byte per read: stay off the line through the nack
            if (n == 8)
                st = 5;
        end
    end
endmodule

// ===== sim/host_serial_bus_byte_access_tb.sv
// Testbench: register-driven byte writes and reads against a model.
// Assumes the engine's quarter counts are shortened by parameter.
module host_serial_bus_byte_access_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [6:0] TGT = 7'h50;
    logic clk;
    logic link_clk;
    logic sys_rst;
    logic [7:0] cfg_addr;
    logic cfg_wr;
    logic [7:0] cfg_wdata;
    logic cfg_rd;
    logic [7:0] cfg_rdata;
    logic scl_oe_n;
    logic sda_oe_n;
    logic sda_low;
    logic [7:0] last_index;
    logic [7:0] last_data;
    logic last_rw;
    logic [7:0] rv;
    int n_mismatch;
    int num_checks;
    int t_norm;
    int t_fast;
    // Open-drain wires with pull-ups
    logic scl_o;
    logic sda_o;
    wire logic scl = scl_oe_n ? 1'b1 : scl_o;
    wire logic sda = (sda_oe_n ? 1'b1 : sda_o) & ~sda_low;
    host_serial_bus_byte_access #(
        .QUARTER_NORMAL_CYC(8),
        .QUARTER_FAST_CYC(2)
    ) i_dut (
        .clk(clk), .sys_rst(sys_rst), .link_clk(link_clk),
        .cfg_addr(cfg_addr), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata),
        .cfg_rd(cfg_rd), .cfg_rdata(cfg_rdata),
        .scl_i(scl), .scl_o(scl_o), .scl_oe_n(scl_oe_n),
        .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n)
    );
    serial_target_model #(.ADDR(TGT)) i_target (
        .scl(scl), .sda(sda), .sda_low(sda_low),
        .last_index(last_index), .last_data(last_data),
        .last_rw(last_rw)
    );
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial
    begin
        link_clk = 1'b0;
        #3;
        forever #6 link_clk = ~link_clk;
    end
    // ------------------------------------------------------------
    // Bus cycles and comparison
    // ------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        cfg_addr = a;
        cfg_wdata = d;
        cfg_wr = 1'b1;
        @(negedge clk);
        cfg_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(negedge clk);
        cfg_addr = a;
        cfg_rd = 1'b1;
        @(negedge clk);
        cfg_rd = 1'b0;
        rv = cfg_rdata;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: %h not %h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        rd(a);
        chk(rv, exp);
    endtask
    task automatic complete_run();
        if (n_mismatch == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Poll busy; the poll count doubles as a duration
    task automatic idle(output int c);
        c = 0;
        rv = 8'hFF;
        while (rv[5] !== 1'b0)
        begin
            rd(8'hB3);
            c++;
            if (c > 4000)
            begin
                n_mismatch++;
                complete_run();
            end
        end
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        rchk(8'hB0, 8'h00);
        rchk(8'hB1, 8'h00);
        rchk(8'hB2, 8'h00);
        wr(8'hB0, 8'hC3);
        wr(8'hB4, 8'hFF);
        rchk(8'hB0, 8'hC3);
        rchk(8'hB4, 8'h00);
    endtask
    task automatic t_write();
        wr(8'hB0, 8'hA5);
        wr(8'hB1, 8'h3C);
        wr(8'hB2, {TGT, 1'b0});
        rchk(8'hB3, 8'h20);
        idle(t_norm);
        chk(last_index, 8'h3C);
        chk(last_data, 8'hA5);
        chk({7'h00, last_rw}, 8'h00);
        rchk(8'hB2, {TGT, 1'b0});
    endtask
    task automatic t_read();
        wr(8'hB0, 8'h00);
        wr(8'hB1, 8'h3C);
        wr(8'hB2, {TGT, 1'b1});
        idle(t_norm);
        rchk(8'hB0, 8'hA5);
        chk({7'h00, last_rw}, 8'h01);
        rchk(8'hB3, 8'h00);
    endtask
    task automatic t_nack();
        wr(8'hB2, {~TGT, 1'b0});
        idle(t_norm);
        rchk(8'hB3, 8'h02);
        wr(8'hB3, 8'h02);
        rchk(8'hB3, 8'h00);
    endtask
    task automatic t_short();
        wr(8'hB3, 8'h80);
        wr(8'hB2, {TGT, 1'b1});
        idle(t_norm);
        rchk(8'hB0, 8'hA5);
        chk(last_index, 8'h3C);
        wr(8'hB0, 8'h5A);
        wr(8'hB2, {TGT, 1'b0});
        idle(t_norm);
        chk(last_index, 8'h5A);
        wr(8'hB3, 8'h00);
    endtask
    task automatic t_speed();
        wr(8'hB2, {TGT, 1'b0});
        idle(t_norm);
        wr(8'hB3, 8'h04);
        rchk(8'hB3, 8'h04);
        wr(8'hB2, {TGT, 1'b0});
        idle(t_fast);
        chk({7'h00, t_fast * 2 < t_norm}, 8'h01);
    endtask
    initial
    begin
        n_mismatch = 0;
        num_checks = 0;
        sys_rst = 1'b1;
        cfg_addr = 8'h00;
        cfg_wr = 1'b0;
        cfg_wdata = 8'h00;
        cfg_rd = 1'b0;
        repeat (8) @(negedge clk);
        sys_rst = 1'b0;
        repeat (4) @(negedge clk);
        t_regs();
        t_write();
        t_read();
        t_nack();
        t_short();
        t_speed();
        complete_run();
    end
endmodule
